// [bench/epv_port_props.sv]
// Pin-level checker for the program/verify port
`timescale 1ns/10ps
`default_nettype none
module epv_port_props (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       verify_output_enable_line,
    input wire logic       mode_p33_pin,
    input wire logic       program_voltage_pin,
    input wire logic       program_pulse_strobe,
    input wire logic [7:0] addr_low_pins,
    input wire logic [4:0] addr_high_pins,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    input wire logic       write_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [1:0] done_cnt_reg;
    logic [1:0] done_cnt_next;
    // Writes taken in the current high-voltage window; saturates to avoid wrap
    always_comb begin
        done_cnt_next = done_cnt_reg;
        if (!program_voltage_pin) done_cnt_next = 2'h0;
        else if (write_done && done_cnt_reg != 2'h3) done_cnt_next = done_cnt_reg + 2'h1;
    end
    // Counter register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) done_cnt_reg <= 2'h0;
        else done_cnt_reg <= done_cnt_next;
    end
    AST_OE_OFF: assert property ((!verify_output_enable_line)[*6] |=> !data_oe) else $error("data driven without oe");
    AST_OE_VPP: assert property (program_voltage_pin[*6] |=> !data_oe) else $error("data driven under vpp");
    AST_OE_MODE: assert property (mode_p33_pin[*6] |=> !data_oe) else $error("data driven outside verify");
    AST_DONE_PULSE: assert property (write_done |=> !write_done) else $error("write_done too long");
    AST_DONE_STROBE: assert property (write_done |-> !$past(program_pulse_strobe, 2)) else $error("write without pulse");
    AST_DONE_VPP: assert property (write_done |-> $past(program_voltage_pin, 6)) else $error("write without vpp");
    AST_ONE_WRITE: assert property (write_done |-> done_cnt_reg == 2'h0) else $error("second write in window");
    AST_DONE_NO_OE: assert property (write_done |-> !data_oe) else $error("driving while writing");
    AST_DOUT_STANDS: assert property (($stable({addr_high_pins, addr_low_pins}) && data_oe)[*6] |=> $stable(data_out))
        else $error("data_out moved");
    cover property (write_done);
    cover property (data_oe && data_out == 8'hFF);
    cover property (data_oe && data_out == 8'hCF);
endmodule
`default_nettype wire

// [bench/epv_prog_model.sv]
// External programmer model driving the mode, address, data and voltage pins
`timescale 1ns/10ps
`default_nettype none
module epv_prog_model (
    input  wire logic       clk,
    output logic [6:0]      mode,
    output logic            program_voltage_pin,
    output logic            program_pulse_strobe,
    output logic [12:0]     addr,
    output logic [7:0]      data,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe
);
    // Idle levels; strobe idles high so a falling edge is a pulse
    initial begin
        mode = 7'h00;
        program_voltage_pin = 1'b0;
        program_pulse_strobe = 1'b1;
        addr = 13'h0000;
        data = 8'h00;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // n is above one only when a scenario deliberately double-pulses
    task automatic program_byte(input logic [6:0] m, input logic [12:0] a, input logic [7:0] d, input int n);
        mode = m;
        wt(2);
        addr = a;
        wt(2);
        data = d;
        wt(6);
        program_voltage_pin = 1'b1;
        repeat (n) begin
            wt(6);
            program_pulse_strobe = 1'b0;
            wt(4);
            program_pulse_strobe = 1'b1;
        end
        wt(8);
        program_voltage_pin = 1'b0;
        wt(6);
        data = ~d; // Released lines no longer show the byte
    endtask
    // Verify read with the oe bit set as asked
    task automatic read_byte(input logic [12:0] a, input logic oe, output logic [7:0] d, output logic e);
        mode = epv_pkg::SEL_VERIFY | {3'h0, oe, 3'h0};
        addr = a;
        wt(8);
        d = data_out;
        e = data_oe;
    endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the program/verify port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk;
    logic        sys_rst;
    logic        erase_req;
    logic [6:0]  mode;
    logic        vpp;
    logic        strobe;
    logic [12:0] addr;
    logic [7:0]  data;
    logic [7:0]  data_out;
    logic        data_oe;
    logic [2:0]  lock_bits;
    logic        write_done;
    logic [7:0]  done_cnt;
    int          error_cnt;
    int          checked;
    epv_port DUT (.clk(clk), .sys_rst(sys_rst), .mode_rst_pin(mode[6]), .fetch_strobe_pin(mode[5]),
        .mode_p26_pin(mode[4]), .verify_output_enable_line(mode[3]), .mode_p33_pin(mode[2]),
        .mode_p36_pin(mode[1]), .mode_p37_pin(mode[0]), .program_voltage_pin(vpp),
        .program_pulse_strobe(strobe), .addr_low_pins(addr[7:0]), .addr_high_pins(addr[12:8]),
        .data_in(data), .data_out(data_out), .data_oe(data_oe), .erase_req(erase_req),
        .lock_bits(lock_bits), .write_done(write_done));
    epv_prog_model prog (.clk(clk), .mode(mode), .program_voltage_pin(vpp), .program_pulse_strobe(strobe),
        .addr(addr), .data(data), .data_out(data_out), .data_oe(data_oe));
    // Clock at 25 MHz
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Counts write pulses independently of the checker
    always @(posedge clk) begin
        if (sys_rst) done_cnt <= 8'h00;
        else if (write_done === 1'b1) done_cnt <= done_cnt + 8'h01;
    end
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       e;
        prog.read_byte(a, 1'b1, d, e);
        chk({7'h00, e}, 8'h01);
        chk(d, exp);
    endtask
    // Erase sweep covers every location, so wait out the full depth
    task automatic t_erase;
        @(negedge clk);
        erase_req = 1'b1;
        prog.wt(4);
        erase_req = 1'b0;
        prog.wt(epv_pkg::DEPTH + 16);
        chk({5'h00, lock_bits}, {5'h00, epv_pkg::LOCK_ERASED});
        rd_chk(13'h0000, epv_pkg::ERASED_BYTE);
        rd_chk(13'h1FFF, epv_pkg::ERASED_BYTE);
    endtask
    // Boundary addresses, a double pulse, and a 1-to-0 overwrite
    task automatic t_prog;
        logic [7:0] n0;
        n0 = done_cnt;
        prog.program_byte(epv_pkg::SEL_PROG_CODE, 13'h0000, 8'hA5, 2);
        chk(done_cnt - n0, 8'h01);
        rd_chk(13'h0000, 8'hA5);
        prog.program_byte(epv_pkg::SEL_PROG_CODE, 13'h1FFF, 8'h3C, 1);
        rd_chk(13'h1FFF, 8'h3C);
        prog.program_byte(epv_pkg::SEL_PROG_CODE, 13'h1FFF, 8'hF0, 1);
        rd_chk(13'h1FFF, 8'h30);
    endtask
    task automatic t_oe;
        logic [7:0] d;
        logic       e;
        prog.read_byte(13'h0000, 1'b0, d, e);
        chk({7'h00, e}, 8'h00);
    endtask
    // Encryption byte only shows through encrypted code reads
    task automatic t_crypt;
        prog.program_byte(epv_pkg::SEL_PROG_CRYPT, 13'h0000, 8'h0F, 1);
        rd_chk(13'h0000, 8'hA5);
        prog.program_byte(epv_pkg::SEL_PROG_LOCK1, 13'h0000, 8'h00, 1);
        rd_chk(13'h0000, 8'hAA);
        rd_chk(13'h1FFF, 8'hCF);
        prog.program_byte(epv_pkg::SEL_PROG_LOCK2, 13'h0000, 8'h00, 1);
        prog.program_byte(epv_pkg::SEL_PROG_LOCK3, 13'h0000, 8'h00, 1);
        chk({5'h00, lock_bits}, 8'h00);
    endtask
    // Erased encryption bytes are all ones, so lock bit 1 turns an erased cell into zeros
    task automatic t_crypt_cleared;
        prog.program_byte(epv_pkg::SEL_PROG_LOCK1, 13'h0000, 8'h00, 1);
        chk({5'h00, lock_bits}, 8'h06);
        rd_chk(13'h0000, epv_pkg::ERASED_BYTE ^ epv_pkg::ERASED_BYTE);
    endtask
    // Guard against a hang
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        error_cnt = 0;
        checked = 0;
        sys_rst = 1'b1;
        erase_req = 1'b0;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        chk({6'h00, data_oe, write_done}, 8'h00);
        t_erase();
        t_prog();
        t_oe();
        t_crypt();
        t_erase();
        t_crypt_cleared();
        tally_and_finish();
    end
endmodule
bind epv_port epv_port_props u_props (.*);
`default_nettype wire

// [core/epv_code_mem.sv]
// Code array storage with registered read data and sweeping erase
`timescale 1ns/10ps
`default_nettype none
module epv_code_mem #(
    parameter int DEPTH = epv_pkg::DEPTH
) (
    input  wire logic   clk,
    input  wire logic   sys_rst,
    epv_mem_if.mem      bus
);
    localparam int AW = epv_pkg::ADDR_W;
    logic [epv_pkg::DATA_W-1:0] cells [DEPTH];
    logic [epv_pkg::ADDR_W-1:0] sweep_reg;
    logic [epv_pkg::ADDR_W-1:0] sweep_next;
    logic                       busy_reg;
    logic                       busy_next;
    logic [epv_pkg::DATA_W-1:0] rdata_reg;

    // Erase walks every cell, one per clock, so a real RAM can be used
    always_comb begin
        sweep_next = sweep_reg;
        busy_next = busy_reg;
        if (bus.erase) begin
            busy_next = 1'b1;
            sweep_next = '0;
        end else if (busy_reg) begin
            sweep_next = sweep_reg + 13'h0001;
            if (sweep_reg == AW'(DEPTH - 1)) begin
                busy_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sweep_reg <= '0;
            busy_reg <= 1'b0;
        end else begin
            sweep_reg <= sweep_next;
            busy_reg <= busy_next;
        end
    end

    // Storage has no reset; erased state is reached only by the sweep
    always_ff @(posedge clk) begin
        if (busy_reg) begin
            cells[sweep_reg] <= epv_pkg::ERASED_BYTE;
        end else if (bus.wr_en) begin
            cells[bus.addr] <= bus.wdata;
        end
        rdata_reg <= cells[bus.addr];
    end

    assign bus.rdata = busy_reg ? epv_pkg::ERASED_BYTE : rdata_reg;
    assign bus.busy = busy_reg;
endmodule
`default_nettype wire

// [core/epv_mem_if.sv]
// Interface between the port logic and the code memory
`timescale 1ns/10ps
`default_nettype none
interface epv_mem_if;
    logic                           wr_en;
    logic                           erase;
    logic [epv_pkg::ADDR_W-1:0]     addr;
    logic [epv_pkg::DATA_W-1:0]     wdata;
    logic [epv_pkg::DATA_W-1:0]     rdata;
    logic                           busy;
    modport ctrl (output wr_en, output erase, output addr, output wdata, input rdata, input busy);
    modport mem  (input wr_en, input erase, input addr, input wdata, output rdata, output busy);
endinterface
`default_nettype wire

// [core/epv_pkg.sv]
// Constants and types shared by the code memory program/verify port
package epv_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int DEPTH = 8192;
    localparam int CRYPT_DEPTH = 64;
    localparam int CRYPT_AW = 6;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [2:0] LOCK_ERASED = 3'h7;
    // Mode-select patterns: {rst, fetch, p26, oe_line, p33, p36, p37}
    localparam logic [6:0] SEL_PROG_CODE = 7'h4F;
    localparam logic [6:0] SEL_PROG_CRYPT = 7'h4D;
    localparam logic [6:0] SEL_PROG_LOCK1 = 7'h5F;
    localparam logic [6:0] SEL_PROG_LOCK2 = 7'h5C;
    localparam logic [6:0] SEL_PROG_LOCK3 = 7'h56;
    // Verify pattern ignores the output-enable line (bit 3)
    localparam logic [6:0] SEL_VERIFY = 7'h43;
    localparam logic [6:0] SEL_VERIFY_MASK = 7'h77;
    typedef enum logic [2:0] {
        EPV_IDLE   = 3'b000,
        EPV_ARMED  = 3'b001,
        EPV_PULSE  = 3'b010,
        EPV_DONE   = 3'b011
    } epv_state_e;
    typedef enum logic [2:0] {
        EPV_T_NONE  = 3'b000,
        EPV_T_CODE  = 3'b001,
        EPV_T_CRYPT = 3'b010,
        EPV_T_LOCK1 = 3'b011,
        EPV_T_LOCK2 = 3'b100,
        EPV_T_LOCK3 = 3'b101
    } epv_target_e;
endpackage

// [core/epv_port.sv]
// Program and verify port logic for the on-chip code memory
`timescale 1ns/10ps
`default_nettype none
module epv_port (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       mode_rst_pin,
    input  wire logic                       fetch_strobe_pin,
    input  wire logic                       mode_p26_pin,
    input  wire logic                       verify_output_enable_line,
    input  wire logic                       mode_p33_pin,
    input  wire logic                       mode_p36_pin,
    input  wire logic                       mode_p37_pin,
    input  wire logic                       program_voltage_pin,
    input  wire logic                       program_pulse_strobe,
    input  wire logic [7:0]                 addr_low_pins,
    input  wire logic [4:0]                 addr_high_pins,
    input  wire logic [7:0]                 data_in,
    output logic [7:0]                      data_out,
    output logic                            data_oe,
    input  wire logic                       erase_req,
    output logic [2:0]                      lock_bits,
    output logic                            write_done
);
    localparam int NSYNC = 10;
    // Strobe stages reset high, the strobe's idle level, so no false pulse follows reset
    localparam logic [NSYNC-1:0] SYNC_IDLE = 10'h002;
    localparam int CAW = epv_pkg::CRYPT_AW;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic [7:0]  dsync1_reg;
    logic [7:0]  dsync2_reg;
    logic [4:0]  ahsync1_reg;
    logic [4:0]  ahsync2_reg;
    logic [7:0]  alsync1_reg;
    logic [7:0]  alsync2_reg;

    epv_mem_if mem_bus ();

    epv_code_mem #(
        .DEPTH (epv_pkg::DEPTH)
    ) u_mem (
        .clk     (clk),
        .sys_rst (sys_rst),
        .bus     (mem_bus)
    );

    // Every pin passes two flip-flops before any logic reads it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_reg <= SYNC_IDLE;
            sync2_reg <= SYNC_IDLE;
            dsync1_reg <= '0;
            dsync2_reg <= '0;
            ahsync1_reg <= '0;
            ahsync2_reg <= '0;
            alsync1_reg <= '0;
            alsync2_reg <= '0;
        end else begin
            sync1_reg <= {mode_rst_pin, fetch_strobe_pin, mode_p26_pin, verify_output_enable_line,
                          mode_p33_pin, mode_p36_pin, mode_p37_pin, program_voltage_pin,
                          program_pulse_strobe, erase_req};
            sync2_reg <= sync1_reg;
            dsync1_reg <= data_in;
            dsync2_reg <= dsync1_reg;
            ahsync1_reg <= addr_high_pins;
            ahsync2_reg <= ahsync1_reg;
            alsync1_reg <= addr_low_pins;
            alsync2_reg <= alsync1_reg;
        end
    end

    logic [6:0]  sel_s;
    logic        vpp_s;
    logic        strobe_s;
    logic        erase_s;
    logic        oe_s;
    logic [12:0] addr_s;
    assign sel_s = sync2_reg[9:3];
    assign oe_s = sync2_reg[6];
    assign vpp_s = sync2_reg[2];
    assign strobe_s = sync2_reg[1];
    assign erase_s = sync2_reg[0];
    assign addr_s = {ahsync2_reg, alsync2_reg};

    // Decode which array a programming cycle aims at
    function automatic epv_pkg::epv_target_e decode_target(input logic [6:0] sel);
        epv_pkg::epv_target_e t;
        t = epv_pkg::EPV_T_NONE;
        case (sel)
            epv_pkg::SEL_PROG_CODE:  t = epv_pkg::EPV_T_CODE;
            epv_pkg::SEL_PROG_CRYPT: t = epv_pkg::EPV_T_CRYPT;
            epv_pkg::SEL_PROG_LOCK1: t = epv_pkg::EPV_T_LOCK1;
            epv_pkg::SEL_PROG_LOCK2: t = epv_pkg::EPV_T_LOCK2;
            epv_pkg::SEL_PROG_LOCK3: t = epv_pkg::EPV_T_LOCK3;
            default:                 t = epv_pkg::EPV_T_NONE;
        endcase
        return t;
    endfunction

    epv_pkg::epv_state_e  state_reg;
    epv_pkg::epv_state_e  state_next;
    epv_pkg::epv_target_e target_reg;
    epv_pkg::epv_target_e target_next;
    logic        prev_strobe_reg;
    logic        fire;
    logic [7:0]  crypt_reg [epv_pkg::CRYPT_DEPTH];
    logic [2:0]  lock_reg;
    logic [2:0]  lock_next;
    logic        done_reg;
    logic        done_next;
    logic        erase_prev_reg;
    logic        erase_fire;

    // Strobe falling edge is the program pulse, under the high voltage only
    assign fire = prev_strobe_reg & ~strobe_s;
    assign erase_fire = erase_s & ~erase_prev_reg;

    // Program sequencer: arm at high voltage, one pulse writes, wait for voltage drop
    always_comb begin
        state_next = state_reg;
        target_next = target_reg;
        lock_next = lock_reg;
        done_next = 1'b0;
        case (state_reg)
            epv_pkg::EPV_IDLE: begin
                if (vpp_s && !mem_bus.busy) begin
                    target_next = decode_target(sel_s);
                    state_next = epv_pkg::EPV_ARMED;
                end
            end
            epv_pkg::EPV_ARMED: begin
                if (!vpp_s) begin
                    state_next = epv_pkg::EPV_IDLE;
                end else if (fire) begin
                    state_next = epv_pkg::EPV_PULSE;
                end
            end
            epv_pkg::EPV_PULSE: begin
                // Writing ones never sets a cell: EPROM programming only clears bits
                case (target_reg)
                    epv_pkg::EPV_T_LOCK1: lock_next[0] = 1'b0;
                    epv_pkg::EPV_T_LOCK2: lock_next[1] = 1'b0;
                    epv_pkg::EPV_T_LOCK3: lock_next[2] = 1'b0;
                    default: lock_next = lock_reg;
                endcase
                done_next = 1'b1;
                state_next = epv_pkg::EPV_DONE;
            end
            epv_pkg::EPV_DONE: begin
                // Further pulses in the same high-voltage window are ignored
                if (!vpp_s) begin
                    state_next = epv_pkg::EPV_IDLE;
                end
            end
            default: state_next = epv_pkg::EPV_IDLE;
        endcase
        if (erase_fire) begin
            state_next = epv_pkg::EPV_IDLE;
            lock_next = epv_pkg::LOCK_ERASED;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= epv_pkg::EPV_IDLE;
            target_reg <= epv_pkg::EPV_T_NONE;
            lock_reg <= epv_pkg::LOCK_ERASED;
            done_reg <= 1'b0;
            prev_strobe_reg <= 1'b1;
            erase_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            target_reg <= target_next;
            lock_reg <= lock_next;
            done_reg <= done_next;
            prev_strobe_reg <= strobe_s;
            erase_prev_reg <= erase_s;
        end
    end

    // Encryption table is write-only from the pins; it reaches data_out only XORed into verify reads while lock bit 1 is programmed
    always_ff @(posedge clk) begin
        for (int i = 0; i < epv_pkg::CRYPT_DEPTH; i++) begin
            if (erase_fire) begin
                crypt_reg[i] <= epv_pkg::ERASED_BYTE;
            end else if (state_reg == epv_pkg::EPV_PULSE && target_reg == epv_pkg::EPV_T_CRYPT
                         && addr_s[epv_pkg::CRYPT_AW-1:0] == CAW'(i)) begin
                crypt_reg[i] <= crypt_reg[i] & dsync2_reg;
            end
        end
    end

    assign mem_bus.erase = erase_fire;
    assign mem_bus.addr = addr_s;
    assign mem_bus.wdata = mem_bus.rdata & dsync2_reg;
    // Write needs the old byte, which the registered read fetched from the same address on the previous clock
    assign mem_bus.wr_en = (state_reg == epv_pkg::EPV_PULSE) && (target_reg == epv_pkg::EPV_T_CODE);

    logic       verify_mode;
    logic [7:0] dout_reg;
    logic [7:0] dout_next;
    logic       oe_reg;
    logic       oe_next;
    assign verify_mode = (sel_s & epv_pkg::SEL_VERIFY_MASK) == epv_pkg::SEL_VERIFY;

    // Verify read: addressed code byte, encrypted when lock bit 1 is programmed
    always_comb begin
        dout_next = mem_bus.rdata;
        if (!lock_reg[0]) begin
            dout_next = mem_bus.rdata ^ crypt_reg[addr_s[epv_pkg::CRYPT_AW-1:0]];
        end
        oe_next = verify_mode && oe_s && !vpp_s;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dout_reg <= '0;
            oe_reg <= 1'b0;
        end else begin
            dout_reg <= dout_next;
            oe_reg <= oe_next;
        end
    end

    assign data_out = dout_reg;
    assign data_oe = oe_reg;
    assign lock_bits = lock_reg;
    assign write_done = done_reg;
endmodule
`default_nettype wire
